// ### design/ifc_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
module ifc_flag_bank #(
    parameter int unsigned W = 7
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] hw_set,
    input  wire logic         wr_stb,
    input  wire logic         wr_dir,
    input  wire logic [W-1:0] wr_bits,
    output logic      [W-1:0] flags
);

    logic [W-1:0] flags_q;
    logic [W-1:0] flags_d;

    always_comb begin
        flags_d = flags_q;
        if (wr_stb) begin
            if (wr_dir) begin
                flags_d = flags_q | wr_bits;
            end else begin
                flags_d = flags_q & ~wr_bits;
            end
        end
        // hardware set applied last so it wins over a clear
        flags_d = flags_d | hw_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;

endmodule
`default_nettype wire

// ### design/ifc_pkg.sv
package ifc_pkg;

    typedef struct packed {
        logic       high_level_alert;
        logic       low_level_alert;
        logic       command_ended;
        logic       unknown_command;
        logic       host_idle_command;
        logic       transmit_done;
        logic       receive_done;
        logic       fifo_write_err;
        logic       fifo_overflow;
        logic       protocol_err;
        logic       missing_data_err;
        logic       integrity_err;
        logic       frame_start;
        logic       card_detected;
        logic [4:0] counter_underflow;
    } ifc_events_t;

    typedef struct packed {
        logic high_level_alert_event;
        logic low_level_alert_event;
        logic command_done_event;
        logic transmit_done_event;
        logic receive_done_event;
        logic fault_event;
        logic frame_start_event;
    } ifc_flags0_t;

    typedef struct packed {
        logic       card_sense_event;
        logic [4:0] counter_underflow_event;
    } ifc_flags1_t;

    typedef enum logic {
        IFC_ST_IDLE,
        IFC_ST_ANSWER
    } ifc_bus_state_t;

endpackage

// ### design/ifc_regs.svh
`ifndef IFC_REGS_SVH
`define IFC_REGS_SVH

`define IFC_IDX_FLAGS0       8'h06
`define IFC_IDX_FLAGS1       8'h07
`define IFC_IDX_GATE0        8'h08
`define IFC_IDX_GATE1        8'h09

`define IFC_DIR_BIT          7
`define IFC_GLOBAL_BIT       6
`define IFC_INVERT_BIT       7
`define IFC_PUSHPULL_BIT     7
`define IFC_PINGATE_BIT      6

`define IFC_FLAGS0_W         7
`define IFC_FLAGS1_W         6

`define IFC_RST_GATE         8'h00
`define IFC_RST_DATA         32'h00000000

`endif

// ### design/ifc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ifc_regs.svh"
module ifc_top (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire ifc_pkg::ifc_events_t events,
    output logic                      irq,
    output logic                      req_pin_out,
    output logic                      req_pin_oe
);

    // bus slave state
    ifc_pkg::ifc_bus_state_t state_q;
    ifc_pkg::ifc_bus_state_t state_d;
    logic [31:0]             prdata_q;
    logic [31:0]             prdata_d;
    logic                    pready_q;
    logic                    pready_d;
    logic                    pslverr_q;
    logic                    pslverr_d;

    // enable registers
    logic [7:0]              gate0_q;
    logic [7:0]              gate0_d;
    logic [7:0]              gate1_q;
    logic [7:0]              gate1_d;

    // global request and pin
    logic                    global_q;
    logic                    global_d;
    logic                    pin_out_q;
    logic                    pin_out_d;
    logic                    pin_oe_q;
    logic                    pin_oe_d;

    // decode
    logic                    in_range;
    logic                    hit_flags0;
    logic                    hit_flags1;
    logic                    hit_gate0;
    logic                    hit_gate1;
    logic                    mapped;
    logic                    wr_fire;
    logic                    wr_flags0;
    logic                    wr_flags1;
    logic                    wr_dir;

    // flags
    ifc_pkg::ifc_flags0_t    set0;
    ifc_pkg::ifc_flags1_t    set1;
    ifc_pkg::ifc_flags0_t    flags0;
    ifc_pkg::ifc_flags1_t    flags1;
    logic [6:0]              flags0_bits;
    logic [5:0]              flags1_bits;
    logic                    pin_level;
    logic                    pin_sense;

    // address decode; low two bits ignored, high bits must be zero
    always_comb begin
        in_range   = (paddr[11:10] == 2'h0);
        hit_flags0 = 1'b0;
        hit_flags1 = 1'b0;
        hit_gate0  = 1'b0;
        hit_gate1  = 1'b0;
        if (in_range && (paddr[9:2] == `IFC_IDX_FLAGS0)) begin
            hit_flags0 = 1'b1;
        end else if (in_range && (paddr[9:2] == `IFC_IDX_FLAGS1)) begin
            hit_flags1 = 1'b1;
        end else if (in_range && (paddr[9:2] == `IFC_IDX_GATE0)) begin
            hit_gate0 = 1'b1;
        end else if (in_range && (paddr[9:2] == `IFC_IDX_GATE1)) begin
            hit_gate1 = 1'b1;
        end
        mapped = hit_flags0 | hit_flags1 | hit_gate0 | hit_gate1;
    end

    // write lands only on the edge that completes the access
    always_comb begin
        wr_fire   = psel & penable & pready_q & pwrite;
        wr_flags0 = wr_fire & hit_flags0;
        wr_flags1 = wr_fire & hit_flags1;
        wr_dir    = pwdata[`IFC_DIR_BIT];
    end

    // hardware event sources for the first flag register
    always_comb begin
        set0.high_level_alert_event = events.high_level_alert;
        set0.low_level_alert_event  = events.low_level_alert;
        // a host-issued idle is deliberately not a source here
        set0.command_done_event     = events.command_ended
                                    | events.unknown_command;
        set0.transmit_done_event    = events.transmit_done;
        set0.receive_done_event     = events.receive_done;
        set0.fault_event            = events.fifo_write_err
                                    | events.fifo_overflow
                                    | events.protocol_err
                                    | events.missing_data_err
                                    | events.integrity_err;
        set0.frame_start_event      = events.frame_start;
    end

    // hardware event sources for the second flag register
    always_comb begin
        set1.card_sense_event        = events.card_detected;
        set1.counter_underflow_event = events.counter_underflow;
    end

    ifc_flag_bank #(
        .W (`IFC_FLAGS0_W)
    ) u_flags0 (
        .pclk    (pclk),
        .presetn (presetn),
        .hw_set  (set0),
        .wr_stb  (wr_flags0),
        .wr_dir  (wr_dir),
        .wr_bits (pwdata[6:0]),
        .flags   (flags0_bits)
    );

    ifc_flag_bank #(
        .W (`IFC_FLAGS1_W)
    ) u_flags1 (
        .pclk    (pclk),
        .presetn (presetn),
        .hw_set  (set1),
        .wr_stb  (wr_flags1),
        .wr_dir  (wr_dir),
        .wr_bits (pwdata[5:0]),
        .flags   (flags1_bits)
    );

    assign flags0 = flags0_bits;
    assign flags1 = flags1_bits;

    // enable registers, plain read/write
    always_comb begin
        gate0_d = gate0_q;
        gate1_d = gate1_q;
        if (wr_fire && hit_gate0) begin
            gate0_d = pwdata[7:0];
        end
        if (wr_fire && hit_gate1) begin
            gate1_d = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate0_q <= `IFC_RST_GATE;
            gate1_q <= `IFC_RST_GATE;
        end else begin
            gate0_q <= gate0_d;
            gate1_q <= gate1_d;
        end
    end

    // global request, rebuilt each cycle from flags and enables
    always_comb begin
        global_d = (|(flags0_bits & gate0_q[6:0]))
                 | (|(flags1_bits & gate1_q[5:0]));
    end

    // pin drive; open-drain can only pull low, so it drives when the
    // sensed level is 0 and relies on an external pull-up otherwise
    always_comb begin
        pin_level = global_q & gate1_q[`IFC_PINGATE_BIT];
        pin_sense = pin_level ^ gate0_q[`IFC_INVERT_BIT];
        if (gate1_q[`IFC_PUSHPULL_BIT]) begin
            pin_out_d = pin_sense;
            pin_oe_d  = 1'b1;
        end else begin
            pin_out_d = 1'b0;
            pin_oe_d  = ~pin_sense;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_q  <= 1'b0;
            pin_out_q <= 1'b0;
            pin_oe_q  <= 1'b0;
        end else begin
            global_q  <= global_d;
            pin_out_q <= pin_out_d;
            pin_oe_q  <= pin_oe_d;
        end
    end

    // one wait state; buys a registered read mux and registered pready
    always_comb begin
        state_d   = state_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        prdata_d  = prdata_q;
        case (state_q)
            ifc_pkg::IFC_ST_IDLE: begin
                if (psel && penable) begin
                    state_d   = ifc_pkg::IFC_ST_ANSWER;
                    pready_d  = 1'b1;
                    pslverr_d = ~mapped;
                    prdata_d  = `IFC_RST_DATA;
                    if (!pwrite) begin
                        if (hit_flags0) begin
                            prdata_d[6:0] = flags0_bits;
                        end else if (hit_flags1) begin
                            prdata_d[`IFC_GLOBAL_BIT] = global_q;
                            prdata_d[5:0] = flags1_bits;
                        end else if (hit_gate0) begin
                            prdata_d[7:0] = gate0_q;
                        end else if (hit_gate1) begin
                            prdata_d[7:0] = gate1_q;
                        end
                    end
                end
            end
            ifc_pkg::IFC_ST_ANSWER: begin
                state_d = ifc_pkg::IFC_ST_IDLE;
            end
            default: begin
                state_d = ifc_pkg::IFC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= ifc_pkg::IFC_ST_IDLE;
            prdata_q  <= `IFC_RST_DATA;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign irq         = global_q;
    assign req_pin_out = pin_out_q;
    assign req_pin_oe  = pin_oe_q;

endmodule
`default_nettype wire

// ### verification/ifc_irq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ifc_monitor (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire ifc_pkg::ifc_events_t events,
    input wire logic                 irq,
    input wire logic                 req_pin_out,
    input wire logic                 req_pin_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle into access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held over two cycles");
    a_err_unmapped: assert property (pready && paddr[11:10] != 2'b00
        |-> pslverr && prdata == 32'h00000000)
        else $error("upper address not refused");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_reset_quiet: assert property ($rose(presetn) |-> !irq && !pready)
        else $error("outputs active just after reset");
    a_irq_cause: assert property (
        $rose(irq) |-> $past(events != '0, 2) || $past(pready && pwrite, 2))
        else $error("request rose with no event or write");
    a_irq_drop: assert property (
        $fell(irq) |-> $past(pready && pwrite, 2))
        else $error("request fell with no write");
    a_pin_drive: assert property (req_pin_out |-> req_pin_oe)
        else $error("pin high level while not driven");
    // pin is one register behind the request or a gate write
    a_pin_follow: assert property (
        $changed({req_pin_out, req_pin_oe}) |-> $past(irq) != $past(irq, 2)
        || $past(pready && pwrite, 2) || !$past(presetn, 2))
        else $error("pin moved with no cause");
endmodule
bind ifc_top ifc_monitor mon_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
    .irq(irq), .req_pin_out(req_pin_out), .req_pin_oe(req_pin_oe));
`default_nettype wire

// ### verification/ifc_pin_host.sv
`timescale 1ns/1ps
`default_nettype none
module ifc_pin_host (
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      pin_level
);
    // pull-up on the board, so a released pin reads high
    assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ifc_regs.svh"
module tb_top;
    localparam logic [11:0] A_F0 = 12'({`IFC_IDX_FLAGS0, 2'b00});
    localparam logic [11:0] A_F1 = 12'({`IFC_IDX_FLAGS1, 2'b00});
    localparam logic [11:0] A_G0 = 12'({`IFC_IDX_GATE0, 2'b00});
    localparam logic [11:0] A_G1 = 12'({`IFC_IDX_GATE1, 2'b00});
    logic                 pclk = 1'b0;
    logic                 presetn = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [11:0]          paddr = 12'h000;
    logic [31:0]          pwdata = 32'h00000000;
    logic [31:0]          prdata;
    logic [31:0]          rd;
    logic                 pready;
    logic                 pslverr;
    logic                 er;
    logic                 irq;
    logic                 pin_out;
    logic                 pin_oe;
    logic                 pin;
    ifc_pkg::ifc_events_t events = '0;
    int                   fail_count = 0;
    int                   check_count = 0;
    always #2.5 pclk = ~pclk;
    ifc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .events(events), .irq(irq), .req_pin_out(pin_out),
        .req_pin_oe(pin_oe));
    ifc_pin_host host_u (.pin_out(pin_out), .pin_oe(pin_oe),
        .pin_level(pin));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) fail_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, {24'h000000, exp});
    endtask
    task automatic pulse(input int i);
        @(posedge pclk);
        events <= ifc_pkg::ifc_events_t'(19'h00001 << i);
        @(posedge pclk);
        events <= '0;
    endtask
    function automatic logic [15:0] ev_exp(input int i);
        if (i < 6) return 16'h0001 << i;
        if (i == 6) return 16'h0100;
        if (i < 12) return 16'h0200;
        if (i == 14) return 16'h0000;
        if (i < 14) return 16'h0400 << (i - 12);
        if (i < 17) return 16'h1000;
        return 16'h2000 << (i - 17);
    endfunction
    task automatic t_reset();
        rdc(A_F0, 8'h00);
        rdc(A_F1, 8'h00);
        rdc(A_G0, 8'h00);
        rdc(A_G1, 8'h00);
        rdc(12'h400, 8'h00);
        chk({31'h0, er}, 32'h00000001);
    endtask
    task automatic t_write_dir();
        wr(A_F0, 8'hFF);
        rdc(A_F0, 8'h7F);
        wr(A_F0, 8'h7F);
        rdc(A_F0, 8'h00);
        wr(A_F0, 8'h85);
        wr(A_F0, 8'h01);
        rdc(A_F0, 8'h04);
        wr(A_F1, 8'hFF);
        rdc(A_F1, 8'h3F);
        wr(A_F1, 8'h25);
        rdc(A_F1, 8'h1A);
        wr(A_F0, 8'h7F);
        wr(A_F1, 8'h7F);
    endtask
    task automatic t_events();
        logic [15:0] e;
        for (int i = 0; i < 19; i++) begin
            e = ev_exp(i);
            pulse(i);
            rdc(A_F0, e[15:8]);
            rdc(A_F1, e[7:0]);
            wr(A_F0, 8'h7F);
            wr(A_F1, 8'h7F);
        end
    endtask
    task automatic t_pin();
        logic [7:0] g1;
        logic       s;
        wr(A_G0, 8'h01);
        pulse(6);
        repeat (4) @(posedge pclk);
        chk({31'h0, irq}, 32'h00000001);
        rdc(A_F1, 8'h40);
        for (int j = 0; j < 6; j++) begin
            g1 = (j / 2 == 0) ? 8'h00 : (j / 2 == 1) ? 8'h40 : 8'hC0;
            s = g1[6] ^ j[0];
            wr(A_G0, j[0] ? 8'h81 : 8'h01);
            wr(A_G1, g1);
            repeat (4) @(posedge pclk);
            chk({pin_oe, pin}, {g1[7] | ~s, s});
        end
        // masking leaves the flag set, only the request drops
        wr(A_G0, 8'h00);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h00000000);
        wr(A_G0, 8'h01);
        wr(A_F0, 8'h01);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h00000000);
        wr(A_G1, 8'h08);
        rdc(A_G1, 8'h08);
        pulse(3);
        repeat (4) @(posedge pclk);
        chk({31'h0, irq}, 32'h00000001);
        wr(A_F1, 8'h08);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h00000000);
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #20000;
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_write_dir();
        t_events();
        t_pin();
        end_sim();
    end
endmodule
`default_nettype wire
